// ---- dv/card_rack_model.sv ----
/* Rack of eight two-bank memory cards seen by the controller.
   Assumes one segment line per card and one shared expansion line. */
`timescale 1ns/1ps
module card_rack_model
	import bank_ctl_pkg::*;
(
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] seg_line_i,
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] jumper_high_i,
	input  wire logic                           memex_i,
	output logic      [bank_ctl_pkg::SEG_W-1:0] card_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] primary_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] expanded_on_o
);
	import bank_ctl_pkg::*;
	// ----
	// Card and bank enables
	// ----
	// Each line comes on its own connector and is read at its jumper level
	assign card_on_o = ~(seg_line_i ^ jumper_high_i);
	// An unselected card or bank enables nothing
	assign primary_on_o = card_on_o & {SEG_W{~memex_i}};
	assign expanded_on_o = card_on_o & {SEG_W{memex_i}};
endmodule

// ---- dv/tb_bank_ctl.sv ----
/* Self-checking bench: drives commands, notes expected state in a queue.
   Assumes bank_ctl_pkg and the card rack model are compiled first. */
`timescale 1ns/1ps
module tb_bank_ctl;
	import bank_ctl_pkg::*;
	logic       core_clk_i, resetn_i, ce_i, cmd_valid_i, memex_o, e_svc;
	logic       in_service_o, cmd_done_o, e_memex, s_memex;
	op_t        cmd_op_i;
	logic [7:0] cmd_data_i, active_high_i, seg_port_o, card_on_o, e_port;
	logic [7:0] primary_on_o, expanded_on_o, m_card, m_pri, m_exp, s_port;
	logic [9:0] notes[$];
	int         miscompares = 0, comparisons = 0, seed = 56523;
	bank_ctl u_bank_ctl(.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.ce_i(ce_i), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
		.cmd_data_i(cmd_data_i), .active_high_i(active_high_i),
		.memex_o(memex_o), .seg_port_o(seg_port_o),
		.in_service_o(in_service_o), .cmd_done_o(cmd_done_o),
		.card_on_o(card_on_o), .primary_on_o(primary_on_o),
		.expanded_on_o(expanded_on_o));
	card_rack_model u_card_rack_model(.seg_line_i(seg_port_o),
		.jumper_high_i(active_high_i), .memex_i(memex_o),
		.card_on_o(m_card), .primary_on_o(m_pri), .expanded_on_o(m_exp));
	// ----
	// Clock, compare and drive tasks
	// ----
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmp_state(input logic [9:0] got, input logic [9:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t state %h wanted %h", $time, got, exp);
		end
	endtask
	task automatic cmp_cards(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t cards %h wanted %h", $time, got, exp);
		end
	endtask
	// Expected state follows every command the design should accept
	task automatic send(input op_t op, input logic [7:0] d);
		@(negedge core_clk_i);
		cmd_valid_i = 1'b1;
		cmd_op_i = op;
		cmd_data_i = d;
		if (ce_i) begin
			case (op)
			OP_SET_MEMEX: e_memex = d[0];
			OP_WRITE_PORT: e_port = d;
			OP_SELECT_CARD: begin
				e_port = ~active_high_i;
				e_port[d[2:0]] = active_high_i[d[2:0]];
			end
			OP_ENTER_SERVICE: if (!e_svc) begin
				{s_memex, s_port} = {e_memex, e_port};
				{e_memex, e_svc} = 2'b01;
			end
			OP_LEAVE_SERVICE: if (e_svc) begin
				{e_memex, e_port} = {s_memex, s_port};
				e_svc = 1'b0;
			end
			default: ;
			endcase
			if (op != OP_NOP)
				notes.push_back({e_memex, e_svc, e_port});
		end
		@(negedge core_clk_i);
		cmd_valid_i = 1'b0;
	endtask
	always @(posedge core_clk_i) begin
		#2;
		if (cmd_done_o === 1'b1) begin
			if (notes.size() == 0)
				cmp_state(10'h3ff, 10'h000);
			else
				cmp_state({memex_o, in_service_o, seg_port_o}, notes.pop_front());
			cmp_cards(card_on_o, m_card);
			cmp_cards(primary_on_o, m_pri);
			cmp_cards(expanded_on_o, m_exp);
		end
	end
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{resetn_i, ce_i, cmd_valid_i, cmd_data_i} = 11'h200;
		cmd_op_i = OP_NOP;
		active_high_i = 8'h5c;
		{e_memex, e_svc, e_port, s_memex, s_port} = 18'h0;
		repeat (6) @(negedge core_clk_i);
		resetn_i = 1'b1;
		@(posedge core_clk_i);
		#2;
		cmp_state({memex_o, in_service_o, seg_port_o}, 10'h000);
		cmp_cards(card_on_o, ~active_high_i);
		for (int i = 0; i < 5; i++)
			send(OP_SET_MEMEX, (8'h06 >> i) & 8'h01);
		for (int i = 0; i < 8; i++)
			send(OP_SELECT_CARD, 8'(i));
		repeat (40) begin
			@(negedge core_clk_i);
			active_high_i = 8'($random(seed));
			send(OP_WRITE_PORT, 8'($random(seed)));
			send(OP_SET_MEMEX, 8'($random(seed)));
		end
		send(OP_SET_MEMEX, 8'h01);
		send(OP_LEAVE_SERVICE, 8'h00);
		send(OP_ENTER_SERVICE, 8'h00);
		send(OP_ENTER_SERVICE, 8'h00);
		send(OP_WRITE_PORT, 8'h3c);
		send(OP_LEAVE_SERVICE, 8'h00);
		send(OP_NOP, 8'h00);
		ce_i = 1'b0;
		send(OP_WRITE_PORT, 8'hff);
		ce_i = 1'b1;
		send(OP_SET_MEMEX, 8'h00);
		repeat (3) @(negedge core_clk_i);
		cmp_cards(8'(notes.size()), 8'h00);
		give_verdict();
	end
endmodule

// ---- verilog/bank_ctl.sv ----
/*
 * Controller that drives the expansion line and an eight-bit segment
 * select port for a rack of byte-wide memory cards.
 * Assumes the user side issues one command per cycle on the same clock,
 * and that active_high_i mirrors the polarity jumpers of the cards.
 */
// How it works
// (R01) Each card takes its segment line from a separate connector, fed here from one port bit.
// (R02) Each card is jumpered for low or high active segment select, mirrored in active_high_i.
// (R03) A card is enabled only while its line sits at its jumpered level.
// (R04) Cards may share addresses; only the card whose line is active answers.
// (R05) The expansion line low enables the primary bank, high the expanded bank.
// (R06) Writing the expansion bit cleared picks primary, set picks expanded, and a rewrite of the same level changes nothing.
// (R07) Each card's segment line is one bit of the eight-bit port, so one port steers eight cards.
// (R08) The port bits come up low after reset, so a low active card is selected at once.
// (R09) Segment select picks the card and the expansion line then picks that card's bank.
// (R10) A card whose segment or bank is not selected drives no data and enables no memory.
`timescale 1ns/1ps
module bank_ctl
	import bank_ctl_pkg::*;
(
	input  wire logic                           core_clk_i,
	input  wire logic                           resetn_i,
	input  wire logic                           ce_i,
	input  wire logic                           cmd_valid_i,
	input  wire bank_ctl_pkg::op_t              cmd_op_i,
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] cmd_data_i,
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] active_high_i,
	output logic                                memex_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] seg_port_o,
	output logic                                in_service_o,
	output logic                                cmd_done_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] card_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] primary_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] expanded_on_o
);
	import bank_ctl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ST_RUN,
		ST_SERVICE
	} mode_t;

	typedef struct packed {
		mode_t              mode;
		logic               memex;
		logic [SEG_W-1:0]   seg_port;
		logic               saved_memex;
		logic [SEG_W-1:0]   saved_port;
		logic               done;
		logic [SEG_W-1:0]   card_on;
		logic [SEG_W-1:0]   prim_on;
		logic [SEG_W-1:0]   exp_on;
	} state_t;

	state_t           st;
	state_t           next_st;
	logic [SEG_W-1:0] view_card;
	logic [SEG_W-1:0] view_prim;
	logic [SEG_W-1:0] view_exp;

	// Enable view is taken from the next port values so the registered
	// report, cleared by reset, lines up with the registered pins from the first enabled edge on.
	card_enable_view u_card_enable_view (
		.seg_port_i    (next_st.seg_port),
		.active_high_i (active_high_i),
		.memex_i       (next_st.memex),
		.card_on_o     (view_card),
		.primary_on_o  (view_prim),
		.expanded_on_o (view_exp)
	);

	// ----------------------------------------------------------------
	// Command handling
	// ----------------------------------------------------------------
	always_comb begin
		next_st      = st;
		next_st.done = 1'b0;
		if (cmd_valid_i) begin
			next_st.done = 1'b1;
			case (cmd_op_i)
				OP_SET_MEMEX: begin
					// Same level again leaves the line untouched [R06] [R05]
					next_st.memex = cmd_data_i[0];
				end
				OP_WRITE_PORT: begin
					next_st.seg_port = cmd_data_i; // [R07] [R01]
				end
				OP_SELECT_CARD: begin
					// Others held inactive so shared addresses never clash
					next_st.seg_port = card_pattern(active_high_i,
						cmd_data_i[IDX_W-1:0]); // [R04] [R02] [R10]
				end
				OP_ENTER_SERVICE: begin
					// Service code lives in primary memory; remember where
					// the interrupted code ran so it can be resumed.
					if (st.mode == ST_RUN) begin
						next_st.saved_memex = st.memex;
						next_st.saved_port  = st.seg_port;
						next_st.memex       = MEMEX_PRIMARY; // [R06]
						next_st.mode        = ST_SERVICE;
					end
				end
				OP_LEAVE_SERVICE: begin
					if (st.mode == ST_SERVICE) begin
						next_st.memex    = st.saved_memex; // [R09]
						next_st.seg_port = st.saved_port;
						next_st.mode     = ST_RUN;
					end
				end
				default: begin
					next_st.done = 1'b0;
				end
			endcase
		end
		next_st.card_on = view_card;
		next_st.prim_on = view_prim;
		next_st.exp_on  = view_exp;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st.mode        <= ST_RUN;
			st.memex       <= MEMEX_RST;
			st.seg_port    <= SEG_PORT_RST; // [R08]
			st.saved_memex <= MEMEX_RST;
			st.saved_port  <= SEG_PORT_RST;
			st.done        <= 1'b0;
			st.card_on     <= '0;
			st.prim_on     <= '0;
			st.exp_on      <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign memex_o       = st.memex;
	assign seg_port_o    = st.seg_port;
	assign in_service_o  = (st.mode == ST_SERVICE);
	assign cmd_done_o    = st.done;
	assign card_on_o     = st.card_on;
	assign primary_on_o  = st.prim_on;
	assign expanded_on_o = st.exp_on;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_enter;
		ce_i && cmd_valid_i && cmd_op_i == OP_ENTER_SERVICE
			&& st.mode == ST_RUN;
	endsequence

	sequence s_leave;
		ce_i && cmd_valid_i && cmd_op_i == OP_LEAVE_SERVICE
			&& st.mode == ST_SERVICE;
	endsequence

	chk_memex_write: assert property ( // [R06]
		@(posedge core_clk_i) disable iff (!resetn_i)
		ce_i && cmd_valid_i && cmd_op_i == OP_SET_MEMEX
		|=> memex_o == $past(cmd_data_i[0]) && cmd_done_o)
		else $error("expansion line not set as written");

	chk_port_hold: assert property ( // [R07]
		@(posedge core_clk_i) disable iff (!resetn_i)
		!(ce_i && cmd_valid_i) |=> $stable(seg_port_o) && $stable(memex_o))
		else $error("port changed with no command");

	chk_reset_low: assert property ( // [R08]
		@(posedge core_clk_i)
		$rose(resetn_i) |-> seg_port_o == SEG_PORT_RST)
		else $error("segment port not low after reset");

	chk_service_trip: assert property ( // [R09]
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_leave
		|=> memex_o == $past(st.saved_memex)
			&& seg_port_o == $past(st.saved_port) && !in_service_o)
		else $error("bank not restored after service");

	chk_service_primary: assert property ( // [R06]
		@(posedge core_clk_i) disable iff (!resetn_i)
		s_enter |=> memex_o == MEMEX_PRIMARY && in_service_o)
		else $error("service did not force primary bank");

	chk_one_card: assert property ( // [R09]
		@(posedge core_clk_i) disable iff (!resetn_i)
		ce_i && cmd_valid_i && cmd_op_i == OP_SELECT_CARD
		|=> $onehot(card_on_o)
			&& card_on_o[$past(cmd_data_i[IDX_W-1:0])])
		else $error("select did not enable exactly one card");

endmodule

// ---- verilog/bank_ctl_pkg.sv ----
/*
 * Constants, command codes and the port pattern helper shared by the
 * bank and segment controller.
 * Assumes one card per segment port bit and one shared expansion line.
 */
package bank_ctl_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int        SEG_W          = 8;
	localparam int        IDX_W          = 3;
	localparam logic [7:0] SEG_PORT_RST  = 8'h00;
	localparam logic      MEMEX_RST      = 1'b0;
	localparam logic      MEMEX_PRIMARY  = 1'b0;
	localparam logic      MEMEX_EXPANDED = 1'b1;

	// ----------------------------------------------------------------
	// Commands
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP,
		OP_SET_MEMEX,
		OP_WRITE_PORT,
		OP_SELECT_CARD,
		OP_ENTER_SERVICE,
		OP_LEAVE_SERVICE
	} op_t;

	// Port pattern that enables card idx and holds every other card off:
	// each bit sits at its card's inactive level except the chosen one.
	function automatic logic [SEG_W-1:0] card_pattern(
		input logic [SEG_W-1:0] active_high,
		input logic [IDX_W-1:0] idx
	);
		logic [SEG_W-1:0] pat;
		pat = ~active_high;
		pat[idx] = active_high[idx];
		return pat;
	endfunction

endpackage

// ---- verilog/card_enable_view.sv ----
/*
 * Works out which card and bank answer for a given segment port value,
 * expansion level and jumper map of card polarities.
 * Assumes the polarity map matches the jumpers fitted on the cards.
 */
`timescale 1ns/1ps
module card_enable_view
	import bank_ctl_pkg::*;
(
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] seg_port_i,
	input  wire logic [bank_ctl_pkg::SEG_W-1:0] active_high_i,
	input  wire logic                           memex_i,
	output logic      [bank_ctl_pkg::SEG_W-1:0] card_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] primary_on_o,
	output logic      [bank_ctl_pkg::SEG_W-1:0] expanded_on_o
);
	import bank_ctl_pkg::*;

	// ----------------------------------------------------------------
	// Per card decode
	// ----------------------------------------------------------------
	for (genvar g = 0; g < SEG_W; g++) begin : g_card
		// A card is on when its line equals its jumpered level [R03] [R04]
		assign card_on_o[g] = ~(seg_port_i[g] ^ active_high_i[g]);
		// Bank picked by expansion line, none when card off [R05] [R09] [R10]
		assign primary_on_o[g]  = card_on_o[g] & (memex_i == MEMEX_PRIMARY);
		assign expanded_on_o[g] = card_on_o[g] & (memex_i == MEMEX_EXPANDED);
	end

endmodule
